//--- hsra_pkg.sv
// Purpose: shared constants, types and CRC helper for the host serial register access block
// Assumes: 20 MHz system clock, 40-bit SPI frames, single-wire datagrams of 4 or 8 bytes
// Notes:   figures used by the logic are named here; the frame length 40 is named twice, as SPI_BITS and SPI_BITS_C
`default_nettype none
package hsra_pkg;
	// clock and baud limits
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          MIN_BAUD      = 9000;
	localparam int          BT_W          = 16;
	localparam logic [15:0] BT_RESET      = 16'(CLK_HZ / MIN_BAUD);
	// spi frame and status byte sources
	localparam int          SPI_BITS      = 40;
	localparam logic [5:0]  SPI_BITS_C    = 6'h28;
	localparam int          SRC_STILL     = 31;
	localparam int          SRC_STALL     = 24;
	localparam int          SRC_DRV_ERR   = 1;
	localparam int          SRC_RST_FLAG  = 0;
	localparam logic [3:0]  STAT_UNUSED   = 4'h0;
	// single-wire datagram layout
	localparam logic [3:0]  SYNC_NIBBLE   = 4'h5;
	localparam logic [7:0]  SYNC_PRELOAD  = 8'hA0;
	localparam logic [6:0]  SYNC_POS      = 7'h04;
	localparam logic [1:0]  SYNC_EDGES    = 2'h2;
	localparam int          SYNC_SHIFT    = 2;
	localparam logic [7:0]  REPLY_NODE    = 8'hFF;
	localparam int          RW_BIT        = 7;
	localparam logic [3:0]  RD_LEN        = 4'h4;
	localparam logic [3:0]  WR_LEN        = 4'h8;
	localparam logic [3:0]  REPLY_LEN     = 4'h8;
	localparam logic [3:0]  FRAME_BITS    = 4'hA;
	localparam logic [6:0]  STOP_POS      = 7'h09;
	// crc
	localparam logic [7:0]  CRC_POLY      = 8'h07;
	localparam logic [7:0]  CRC_INIT      = 8'h00;
	// timeouts, in bit times unless noted
	localparam logic [6:0]  GAP_BITS      = 7'h3F;
	localparam logic [6:0]  RECOVER_BITS  = 7'h0C;
	localparam logic [15:0] GLITCH_CYC    = 16'h0010;
	localparam int          DELAY_SHIFT   = 3;
	localparam logic [6:0]  TAIL_BITS     = 7'h04;

	// one register access toward the register file
	typedef struct packed {
		logic        write;
		logic [6:0]  addr;
		logic [31:0] data;
	} hsra_req_s;

	// crc over one byte, least significant bit first
	function automatic logic [7:0] hsra_crc8(input logic [7:0] crc, input logic [7:0] b);
		logic [7:0] c;
		c = crc;
		for (int j = 0; j < 8; j++) begin
			c = (c[7] ^ b[j]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
endpackage
`default_nettype wire

//--- hsra_uart_tx.sv
// Purpose: one byte onto the single-wire line, start bit, eight bits lsb first, stop bit
// Assumes: bit time given in system clocks, at least one
// Notes:   line idles high; idle_o is high when the next byte may be started
`timescale 1ns/1ps
`default_nettype none
module hsra_uart_tx #(
	parameter int BT_W = hsra_pkg::BT_W
) (
	// clock and reset
	input  wire logic            ref_clk_i,
	input  wire logic            nrst_i,
	// byte request
	input  wire logic [BT_W-1:0] bit_time_i,
	input  wire logic            go_i,
	input  wire logic [7:0]      byte_i,
	// line side
	output logic                 line_o,
	output logic                 idle_o
);
	import hsra_pkg::*;

	logic [9:0]      sh_r;
	logic [3:0]      nbit_r;
	logic [BT_W-1:0] ph_r;

	assign idle_o = (nbit_r == 4'h0);

	// frame shifter; fill with ones so the line rests high after the stop bit
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sh_r   <= 10'h3FF;
			nbit_r <= 4'h0;
			ph_r   <= '0;
			line_o <= 1'b1;
		end else if (go_i && idle_o) begin
			sh_r   <= {1'b1, byte_i, 1'b0};
			nbit_r <= FRAME_BITS;
			ph_r   <= '0;
			line_o <= 1'b0;
		end else if (!idle_o) begin
			if (ph_r == bit_time_i - 1'b1) begin
				ph_r   <= '0;
				sh_r   <= {1'b1, sh_r[9:1]};
				line_o <= sh_r[1];
				nbit_r <= nbit_r - 1'b1;
			end else begin
				ph_r <= ph_r + 1'b1;
			end
		end
	end

	a_tx_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(go_i && idle_o) |=> (!line_o && !idle_o))
		else $error("byte start did not drive a low start bit");
endmodule
`default_nettype wire

//--- hsra_top.sv
// Purpose: register access port, SPI peripheral or single-wire UART node
// Assumes: register file answers rd_data_i in the cycle req_valid_o is high
// Notes:   SPI pins are sampled with two flops; SCK must stay well below a quarter of ref_clk_i
//
// Notes on behaviour
// - status bits 7..4 zero; bit 3 is the motor standstill flag
// - status bit 2 carries the stall detect flag
// - status bits 1,0 show drive fault and reset flags, cleared by register file
// - data field right aligned, passed to registers untouched
// - sample on rising SCK, shift out after falling SCK, MSB first
// - extra bits come out delayed by forty SCK clocks for daisy chains
// - chip select rise commits the last forty bits only
// - bytes framed start low, stop high, LSB first; words high byte first
// - datagram starts with sync nibble, reserved bits, then node byte
// - bit time measured start fall to sync bit 3 fall, every datagram
// - node address is base value plus the three address pins
// - register byte bit 7 chooses write when set, read when clear
// - over 63 bit times between starts resets reception; 12 idle bits needed
// - glitch under sixteen clocks or bad CRC needs 12 idle bits
// - eight-bit wrapping counter counts accepted writes, readable by host
// - read request is four bytes, reply at the request's baud
// - reply waits a delay in steps of eight bit times, default eight
// - CRC8 polynomial 0x07, zero start, LSB first, over all bytes
// - read reply carries node byte all ones, register byte, 32 data bits
// - driver stays on four bit times after last reply bit
// - each SPI transfer returns status and previous read or write data
`timescale 1ns/1ps
`default_nettype none
module hsra_top (
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              nrst_i,
	// mode and configuration
	input  wire logic              uart_mode_i,
	input  wire logic [7:0]        node_address_base_i,
	input  wire logic [3:0]        reply_delay_setting_i,
	// spi pins, also the address pins in uart mode
	input  wire logic              spi_sck_i,
	input  wire logic              chip_select_n_i,
	input  wire logic              serial_in_i,
	output logic                   serial_out_o,
	// single-wire line
	input  wire logic              single_wire_line_i,
	output logic                   single_wire_line_o,
	output logic                   single_wire_line_oe_o,
	// driver status sources
	input  wire logic [31:0]       driver_state_word_i,
	input  wire logic [1:0]        global_flag_word_i,
	// register file access
	output logic                   req_valid_o,
	output hsra_pkg::hsra_req_s    req_o,
	input  wire logic [31:0]       rd_data_i,
	// uart bookkeeping
	output logic [7:0]             write_ack_count_o,
	output logic                   uart_error_o
);
	import hsra_pkg::*;

	typedef enum logic [2:0] {
		U_IDLE    = 3'b000,
		U_SYNC    = 3'b001,
		U_BYTE    = 3'b010,
		U_GAP     = 3'b011,
		U_RECOVER = 3'b100,
		U_DELAY   = 3'b101,
		U_REPLY   = 3'b110,
		U_TAIL    = 3'b111
	} hsra_ust_e;

	logic [2:0]      sck_s, cs_s, sdi_s, ln_s;
	logic            sck_rise, sck_fall, cs_fall, cs_rise, ln_fall;
	logic [39:0]     spi_sh_r;
	logic [5:0]      spi_cnt_r;
	logic [7:0]      status_byte;
	logic            spi_commit;
	logic [31:0]     reply_r;
	hsra_ust_e       st_r;
	logic [BT_W-1:0] bt_r, phase_r, half;
	logic [15:0]     t_r;
	logic            tick;
	logic [6:0]      pos_r, delay_bits;
	logic [1:0]      nedge_r;
	logic [7:0]      byte_r, crc_r, node_sel, node_at, tx_byte_r, reply_byte;
	logic [63:0]     dg_r;
	logic [3:0]      nbyte_r, tx_idx_r;
	logic            is_last, acc_rd_r, acc_wr_r, tx_go_r, tx_idle;
	hsra_req_s       uart_req_r;
	logic [7:0]      wr_cnt_r;

	// pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_s <= 3'h7;
			cs_s  <= 3'h7;
			sdi_s <= 3'h0;
			ln_s  <= 3'h7;
		end else begin
			sck_s <= {sck_s[1:0], spi_sck_i};
			cs_s  <= {cs_s[1:0], chip_select_n_i};
			sdi_s <= {sdi_s[1:0], serial_in_i};
			ln_s  <= {ln_s[1:0], single_wire_line_i};
		end
	end

	assign sck_rise = sck_s[1] & ~sck_s[2];
	assign sck_fall = ~sck_s[1] & sck_s[2];
	assign cs_fall  = ~cs_s[1] & cs_s[2];
	assign cs_rise  = cs_s[1] & ~cs_s[2];
	assign ln_fall  = ~ln_s[1] & ln_s[2];

	// status byte as seen when the frame opens
	assign status_byte = {STAT_UNUSED,
		driver_state_word_i[SRC_STILL],
		driver_state_word_i[SRC_STALL],
		global_flag_word_i[SRC_DRV_ERR], global_flag_word_i[SRC_RST_FLAG]};

	// spi shift register; short frames are dropped rather than half-applied
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			spi_sh_r     <= '0;
			spi_cnt_r    <= '0;
			serial_out_o <= 1'b0;
		end else if (cs_fall) begin
			spi_sh_r     <= {status_byte, reply_r};
			spi_cnt_r    <= '0;
			serial_out_o <= status_byte[7];
		end else if (!cs_s[1]) begin
			if (sck_rise) begin
				spi_sh_r <= {spi_sh_r[38:0], sdi_s[1]};
				if (spi_cnt_r != SPI_BITS_C) spi_cnt_r <= spi_cnt_r + 1'b1;
			end
			if (sck_fall) serial_out_o <= spi_sh_r[SPI_BITS-1];
		end
	end

	assign spi_commit = cs_rise && !uart_mode_i && (spi_cnt_r == SPI_BITS_C);

	// bit timing shared by every uart state
	assign half = bt_r >> 1;
	assign tick = (phase_r == bt_r - 1'b1);
	assign node_sel = node_address_base_i + 8'({cs_s[1], sck_s[1], sdi_s[1]});
	assign is_last = ((nbyte_r == RD_LEN - 1'b1) && !dg_r[RW_BIT]) || (nbyte_r == WR_LEN - 1'b1);
	// a write is known by its length; bit 7 of the last shifted byte is data then
	assign node_at = (nbyte_r == WR_LEN - 1'b1) ? dg_r[47:40] : dg_r[15:8];
	assign delay_bits = 7'((reply_delay_setting_i == 4'h0) ? 4'h1 : reply_delay_setting_i) << DELAY_SHIFT;

	// reply byte order: sync, all-ones node, register, data high to low, crc
	always_comb begin
		unique case (tx_idx_r)
			4'h0:    reply_byte = {4'h0, SYNC_NIBBLE};
			4'h1:    reply_byte = REPLY_NODE;
			4'h2:    reply_byte = {1'b0, uart_req_r.addr};
			4'h3:    reply_byte = reply_r[31:24];
			4'h4:    reply_byte = reply_r[23:16];
			4'h5:    reply_byte = reply_r[15:8];
			4'h6:    reply_byte = reply_r[7:0];
			default: reply_byte = crc_r;
		endcase
	end

	// single-wire receive, timeout and reply sequencer
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r                  <= U_IDLE;
			bt_r                  <= BT_RESET;
			phase_r               <= '0;
			t_r                   <= '0;
			pos_r                 <= '0;
			nedge_r               <= '0;
			byte_r                <= '0;
			dg_r                  <= '0;
			nbyte_r               <= '0;
			crc_r                 <= CRC_INIT;
			acc_rd_r              <= 1'b0;
			acc_wr_r              <= 1'b0;
			uart_error_o          <= 1'b0;
			uart_req_r            <= '0;
			tx_go_r               <= 1'b0;
			tx_byte_r             <= '0;
			tx_idx_r              <= '0;
			single_wire_line_oe_o <= 1'b0;
		end else begin
			acc_rd_r     <= 1'b0;
			acc_wr_r     <= 1'b0;
			uart_error_o <= 1'b0;
			tx_go_r      <= 1'b0;
			phase_r      <= tick ? '0 : phase_r + 1'b1;
			if (tick) pos_r <= pos_r + 1'b1;
			unique case (st_r)
				U_IDLE: begin
					phase_r <= '0;
					pos_r   <= '0;
					nedge_r <= '0;
					if (uart_mode_i && ln_fall) begin
						t_r     <= 16'h0001;
						nbyte_r <= '0;
						crc_r   <= CRC_INIT;
						st_r    <= U_SYNC;
					end
				end
				U_SYNC: begin
					t_r <= t_r + 1'b1;
					if (ln_fall) begin
						if (nedge_r == SYNC_EDGES - 1'b1) begin
							bt_r    <= BT_W'(t_r >> SYNC_SHIFT);
							phase_r <= '0;
							pos_r   <= SYNC_POS;
							byte_r  <= SYNC_PRELOAD;
							st_r    <= U_BYTE;
						end else begin
							nedge_r <= nedge_r + 1'b1;
						end
					end else if ((ln_s[1] && t_r < GLITCH_CYC) || (&t_r)) begin
						st_r         <= U_RECOVER;
						pos_r        <= '0;
						phase_r      <= '0;
						uart_error_o <= 1'b1;
					end
				end
				U_BYTE: begin
					if (phase_r == half && pos_r >= 7'h01 && pos_r < STOP_POS)
						byte_r <= {ln_s[1], byte_r[7:1]};
					if (phase_r == half && pos_r == STOP_POS) begin
						if (!ln_s[1]) begin
							st_r         <= U_RECOVER;
							pos_r        <= '0;
							phase_r      <= '0;
							uart_error_o <= 1'b1;
						end else begin
							dg_r    <= {dg_r[55:0], byte_r};
							nbyte_r <= nbyte_r + 1'b1;
							crc_r   <= hsra_crc8(crc_r, byte_r);
							st_r    <= U_GAP;
							if (is_last) begin
								if (byte_r != crc_r) begin
									st_r         <= U_RECOVER;
									pos_r        <= '0;
									phase_r      <= '0;
									uart_error_o <= 1'b1;
								end else if (node_at != node_sel) begin
									st_r <= U_IDLE;
								end else if (nbyte_r == WR_LEN - 1'b1) begin
									acc_wr_r   <= 1'b1;
									uart_req_r <= '{write: 1'b1, addr: dg_r[38:32], data: dg_r[31:0]};
									st_r       <= U_IDLE;
								end else begin
									acc_rd_r   <= 1'b1;
									uart_req_r <= '{write: 1'b0, addr: dg_r[6:0], data: '0};
									pos_r      <= '0;
									phase_r    <= '0;
									st_r       <= U_DELAY;
								end
							end
						end
					end
				end
				U_GAP: begin
					if (ln_fall) begin
						phase_r <= '0;
						pos_r   <= '0;
						st_r    <= U_BYTE;
					end else if (pos_r > GAP_BITS) begin
						st_r         <= U_RECOVER;
						pos_r        <= '0;
						phase_r      <= '0;
						uart_error_o <= 1'b1;
					end
				end
				U_RECOVER: begin
					if (!ln_s[1]) begin
						pos_r   <= '0;
						phase_r <= '0;
					end else if (pos_r == RECOVER_BITS) begin
						st_r <= U_IDLE;
					end
				end
				U_DELAY: begin
					if (pos_r == delay_bits) begin
						st_r                  <= U_REPLY;
						single_wire_line_oe_o <= 1'b1;
						tx_idx_r              <= '0;
						crc_r                 <= CRC_INIT;
					end
				end
				U_REPLY: begin
					if (tx_idle && !tx_go_r) begin
						if (tx_idx_r == REPLY_LEN) begin
							st_r    <= U_TAIL;
							pos_r   <= '0;
							phase_r <= '0;
						end else begin
							tx_go_r   <= 1'b1;
							tx_byte_r <= reply_byte;
							crc_r     <= hsra_crc8(crc_r, reply_byte);
							tx_idx_r  <= tx_idx_r + 1'b1;
						end
					end
				end
				U_TAIL: begin
					if (pos_r == TAIL_BITS) begin
						single_wire_line_oe_o <= 1'b0;
						st_r                  <= U_IDLE;
					end
				end
			endcase
		end
	end

	// reply uses the bit time measured on the request
	hsra_uart_tx #(.BT_W(BT_W)) u_tx (
		.ref_clk_i  (ref_clk_i),
		.nrst_i     (nrst_i),
		.bit_time_i (bt_r),
		.go_i       (tx_go_r),
		.byte_i     (tx_byte_r),
		.line_o     (single_wire_line_o),
		.idle_o     (tx_idle)
	);

	// request port and the data handed back on the next access
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_valid_o <= 1'b0;
			req_o       <= '0;
			reply_r     <= '0;
		end else begin
			req_valid_o <= spi_commit | acc_rd_r | acc_wr_r;
			if (spi_commit)
				req_o <= '{write: spi_sh_r[39], addr: spi_sh_r[38:32], data: spi_sh_r[31:0]};
			else if (acc_rd_r || acc_wr_r)
				req_o <= uart_req_r;
			if (req_valid_o)
				reply_r <= req_o.write ? req_o.data : rd_data_i;
		end
	end

	// write acknowledge counter, wraps at eight bits
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) wr_cnt_r <= '0;
		else if (acc_wr_r) wr_cnt_r <= wr_cnt_r + 1'b1;
	end
	assign write_ack_count_o = wr_cnt_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_rd_accept;
		acc_rd_r ##1 req_valid_o && !req_o.write;
	endsequence

	a_status_load: assert property (cs_fall |=> spi_sh_r[39:32] == $past(status_byte))
		else $error("status byte not loaded at frame start");
	a_spi_commit: assert property (spi_commit |=> req_valid_o && req_o.data == $past(spi_sh_r[31:0]))
		else $error("full spi frame not committed");
	a_spi_short: assert property (cs_rise && spi_cnt_r != SPI_BITS_C && !acc_rd_r && !acc_wr_r |=> !req_valid_o)
		else $error("short spi frame committed");
	a_sdo_msb: assert property (sck_fall && !cs_s[1] && !cs_fall |=> serial_out_o == $past(spi_sh_r[39]))
		else $error("serial out not taken from top bit");
	a_daisy_shift: assert property (sck_rise && !cs_s[1] && !cs_fall |=> spi_sh_r == {$past(spi_sh_r[38:0]), $past(sdi_s[1])})
		else $error("shift register did not advance");
	a_baud_measure: assert property (st_r == U_SYNC && ln_fall && nedge_r == 2'h1 |=> bt_r == BT_W'($past(t_r) >> 2))
		else $error("bit time not taken from sync edges");
	a_glitch_err: assert property (st_r == U_SYNC && ln_s[1] && t_r < 16'h0010 && !ln_fall |=> st_r == U_RECOVER && uart_error_o)
		else $error("short pulse not treated as error");
	a_wr_count: assert property (acc_wr_r |=> wr_cnt_r == $past(wr_cnt_r) + 8'h01)
		else $error("write counter did not advance");
	a_rd_count: assert property (s_rd_accept |-> $stable(wr_cnt_r))
		else $error("read changed write counter");
	a_reply_node: assert property (st_r == U_REPLY && tx_go_r && tx_idx_r == 4'h2 |-> tx_byte_r == 8'hFF)
		else $error("reply node byte not all ones");
	a_tail_release: assert property ($fell(single_wire_line_oe_o) |-> $past(st_r) == U_TAIL && $past(pos_r) == 7'h04)
		else $error("driver released at wrong time");
	a_reply_delay: assert property ($rose(st_r == U_REPLY) |-> $past(pos_r) == $past(delay_bits) && $past(pos_r) >= 7'h08)
		else $error("reply started before delay");
endmodule
`default_nettype wire

//--- hsra_host_model.sv
// Purpose: host side, spi controller in mode 3 and single-wire uart host
// Assumes: line level resolved outside with a pull-up
// Notes:   bit_time in system clocks, set by the bench
`timescale 1ns/1ps
`default_nettype none
module hsra_host_model (
	// clock
	input  wire logic ref_clk_i,
	// spi pins, address pins in uart mode
	output logic      spi_sck_o,
	output logic      chip_select_n_o,
	output logic      serial_in_o,
	input  wire logic serial_out_i,
	// single-wire line
	output logic      line_drive_o,
	input  wire logic line_i
);
	int bit_time = 40;
	// idle levels at time zero
	initial begin
		spi_sck_o       = 1'b1;
		chip_select_n_o = 1'b1;
		serial_in_o     = 1'b0;
		line_drive_o    = 1'b1;
	end
	task automatic clk(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// six clocks a phase so the pin synchronisers keep up
	task automatic spi_xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
		rx = '0;
		chip_select_n_o <= 1'b0;
		clk(6);
		for (int i = n - 1; i >= 0; i--) begin
			spi_sck_o   <= 1'b0;
			serial_in_o <= tx[i];
			clk(6);
			rx = {rx[62:0], serial_out_i};
			spi_sck_o <= 1'b1;
			clk(6);
		end
		chip_select_n_o <= 1'b1;
		serial_in_o     <= ~serial_in_o; // a released data line keeps no value
		clk(8);
	endtask
	task automatic set_pins(input logic [2:0] p);
		{chip_select_n_o, spi_sck_o, serial_in_o} <= p;
	endtask
	function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
		for (int j = 0; j < 8; j++) begin
			c = (c[7] ^ b[j]) ? ((c << 1) ^ 8'h07) : (c << 1);
		end
		return c;
	endfunction
	// start low, eight bits lsb first, stop high
	task automatic tx_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_drive_o <= f[i];
			clk(bit_time);
		end
	endtask
	// bytes high first, then their crc, spoiled on request
	task automatic send(input logic [7:0] d[$], input logic spoil);
		logic [7:0] c;
		c = 8'h00;
		foreach (d[i]) begin
			tx_byte(d[i]);
			c = crc_byte(c, d[i]);
		end
		tx_byte(c ^ {7'h00, spoil});
	endtask
	// returns at the middle of the stop bit
	task automatic rx_byte(output logic [7:0] b);
		int k;
		k = 0;
		while (line_i !== 1'b0 && k < 4000) begin
			clk(1);
			k++;
		end
		clk(bit_time + bit_time / 2);
		for (int i = 0; i < 8; i++) begin
			b[i] = line_i;
			clk(bit_time);
		end
	endtask
	task automatic glitch();
		line_drive_o <= 1'b0;
		clk(10);
		line_drive_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- hsra_top_bench.sv
// Purpose: self-checking bench for the register access port in both modes
// Assumes: host model drives the pins; the register file is modelled here
// Notes:   requests are noted in a queue and a watcher compares them
`timescale 1ns/1ps
`default_nettype none
module hsra_top_bench;
	import hsra_pkg::*;
	logic        ref_clk_i;
	logic        nrst_i;
	logic        uart_mode_i;
	logic [7:0]  node_address_base_i;
	logic [3:0]  reply_delay_setting_i;
	logic        spi_sck_i;
	logic        chip_select_n_i;
	logic        serial_in_i;
	logic        serial_out_o;
	logic        single_wire_line_o;
	logic        single_wire_line_oe_o;
	logic        host_line;
	wire         line_w;
	logic [31:0] driver_state_word_i;
	logic [1:0]  global_flag_word_i;
	logic        req_valid_o;
	hsra_req_s   req_o;
	logic [31:0] rd_data_i;
	logic [31:0] rd_base;
	logic [7:0]  write_ack_count_o;
	logic        uart_error_o;
	int          fails;
	int          check_count;
	int          err_n;
	hsra_req_s   exp_q[$];
	hsra_req_s   exp_r;
	// pull-up on the shared line, any driver pulls low
	assign line_w    = (single_wire_line_oe_o ? single_wire_line_o : 1'b1) & host_line;
	assign rd_data_i = rd_base ^ {25'h0, req_o.addr};
	hsra_top u_hsra_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .uart_mode_i(uart_mode_i),
		.node_address_base_i(node_address_base_i), .reply_delay_setting_i(reply_delay_setting_i),
		.spi_sck_i(spi_sck_i), .chip_select_n_i(chip_select_n_i), .serial_in_i(serial_in_i),
		.serial_out_o(serial_out_o), .single_wire_line_i(line_w), .single_wire_line_o(single_wire_line_o),
		.single_wire_line_oe_o(single_wire_line_oe_o), .driver_state_word_i(driver_state_word_i),
		.global_flag_word_i(global_flag_word_i), .req_valid_o(req_valid_o), .req_o(req_o),
		.rd_data_i(rd_data_i), .write_ack_count_o(write_ack_count_o), .uart_error_o(uart_error_o));
	hsra_host_model u_hsra_host_model (.ref_clk_i(ref_clk_i), .spi_sck_o(spi_sck_i),
		.chip_select_n_o(chip_select_n_i), .serial_in_o(serial_in_i), .serial_out_i(serial_out_o),
		.line_drive_o(host_line), .line_i(line_w));
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watcher: every request must match the oldest note
	always @(posedge ref_clk_i) begin
		if (uart_error_o === 1'b1)
			err_n++;
		if (req_valid_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(64'h1, 64'h0);
			end else begin
				exp_r = exp_q.pop_front();
				check(64'({req_o.write, req_o.addr, req_o.write ? req_o.data : 32'h0}),
					64'({exp_r.write, exp_r.addr, exp_r.write ? exp_r.data : 32'h0}));
			end
		end
	end
	initial begin
		repeat (80000) @(posedge ref_clk_i);
		fails++;
		give_verdict();
	end
	task automatic do_reset(input logic m);
		nrst_i      <= 1'b0;
		uart_mode_i <= m;
		repeat (5) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		check(64'(write_ack_count_o), 64'h0);
	endtask
	task automatic uart_write(input logic [7:0] node, input logic spoil, input logic hit);
		logic [31:0] d;
		logic [6:0]  a;
		d = $urandom;
		a = 7'($urandom);
		if (hit && !spoil)
			exp_q.push_back({1'b1, a, d});
		u_hsra_host_model.send('{8'h05, node, {1'b1, a}, d[31:24], d[23:16], d[15:8], d[7:0]}, spoil);
		repeat (20) @(posedge ref_clk_i);
	endtask
	task automatic uart_read(input logic [7:0] node);
		logic [6:0]  a;
		logic [31:0] d;
		logic [7:0]  b;
		logic [7:0]  e[8];
		int          k;
		int          bt;
		int          dl;
		bt = u_hsra_host_model.bit_time;
		a = 7'($urandom);
		d = rd_base ^ {25'h0, a};
		e = '{8'h05, 8'hFF, {1'b0, a}, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
		e[7] = 8'h00;
		for (int i = 0; i < 7; i++)
			e[7] = u_hsra_host_model.crc_byte(e[7], e[i]);
		exp_q.push_back({1'b0, a, 32'h0});
		u_hsra_host_model.send('{8'h05, node, {1'b0, a}}, 1'b0);
		k = 0;
		while (single_wire_line_oe_o !== 1'b1 && k < 3000) begin
			@(posedge ref_clk_i);
			k++;
		end
		// setting 0 behaves as 1, eight bit times per step
		dl = 8 * ((reply_delay_setting_i == 4'h0) ? 1 : int'(reply_delay_setting_i));
		check(64'(k >= (dl - 1) * bt && k <= dl * bt), 64'h1);
		foreach (e[i]) begin
			u_hsra_host_model.rx_byte(b);
			check(64'(b), 64'(e[i]));
		end
		k = 0;
		while (single_wire_line_oe_o === 1'b1 && k < 3000) begin
			@(posedge ref_clk_i);
			k++;
		end
		check(64'(k >= 4 * bt && k <= 5 * bt), 64'h1);
	endtask
	initial begin
		logic [63:0] tx;
		logic [63:0] rx;
		logic [31:0] prev;
		logic [7:0]  node;
		logic [2:0]  pins;
		int          lens[5];
		int          n0;
		nrst_i                = 1'b0;
		uart_mode_i           = 1'b0;
		node_address_base_i   = 8'h00;
		reply_delay_setting_i = 4'h2;
		driver_state_word_i   = 32'h0;
		global_flag_word_i    = 2'h0;
		void'($urandom(32'hB957));
		rd_base = $urandom;
		lens = '{40, 40, 32, 48, 40};
		prev = 32'h0;
		do_reset(1'b0);
		// spi frames: full, short and daisy-chained lengths
		foreach (lens[i]) begin
			tx = {$urandom, $urandom};
			driver_state_word_i <= $urandom;
			global_flag_word_i  <= 2'($urandom);
			@(posedge ref_clk_i);
			if (lens[i] >= 40)
				exp_q.push_back(hsra_req_s'(tx[39:0]));
			u_hsra_host_model.spi_xfer(lens[i], tx, rx);
			check((rx >> (lens[i] - 8)) & 64'hFF, 64'({4'h0, driver_state_word_i[31],
				driver_state_word_i[24], global_flag_word_i}));
			if (lens[i] >= 40) begin
				check((rx >> (lens[i] - 40)) & 64'hFFFF_FFFF, 64'(prev));
				prev = tx[39] ? tx[31:0] : rd_base ^ {25'h0, tx[38:32]};
			end
			if (lens[i] == 48)
				check(rx & 64'hFF, 64'(tx[47:40]));
		end
		// single-wire mode after a second reset
		pins = 3'($urandom);
		u_hsra_host_model.set_pins(pins);
		node_address_base_i <= 8'($urandom % 201);
		do_reset(1'b1);
		node = node_address_base_i + {5'h0, pins};
		uart_write(node, 1'b0, 1'b1);
		check(64'(write_ack_count_o), 64'h1);
		uart_read(node);
		uart_write(node + 8'h01, 1'b0, 1'b0);
		check(64'(write_ack_count_o), 64'h1);
		// spoiled crc, over-long gap, glitch
		for (int k = 0; k < 3; k++) begin
			n0 = err_n;
			case (k)
				0: uart_write(node, 1'b1, 1'b1);
				1: begin
					u_hsra_host_model.tx_byte(8'h05);
					u_hsra_host_model.clk(70 * u_hsra_host_model.bit_time);
				end
				default: u_hsra_host_model.glitch();
			endcase
			u_hsra_host_model.clk(14 * u_hsra_host_model.bit_time);
			check(64'(err_n - n0), 64'h1);
		end
		// faster host: bit time readjusts per datagram
		u_hsra_host_model.bit_time = 24;
		uart_write(node, 1'b0, 1'b1);
		check(64'(write_ack_count_o), 64'h2);
		// shortest reply delay, setting zero
		reply_delay_setting_i <= 4'h0;
		uart_read(node);
		check(64'(write_ack_count_o), 64'h2);
		give_verdict();
	end
endmodule
`default_nettype wire
